// ---- pkg/bdsr_pkg.sv ----
// backlight diagnostic status bank: shared constants and types
// assumes a 32-bit AXI4-Lite master and word-aligned registers
package bdsr_pkg;
   // ----------------------------------------
   // register indices (byte address = 4 x index)
   // ----------------------------------------
   localparam int         ADDR_W    = 8;
   localparam logic [7:0] IDX_FLAGS = 8'h12;
   localparam logic [7:0] IDX_FSM   = 8'h14;
   localparam logic [7:0] IDX_PIN   = 8'h16;
   localparam logic [7:0] IDX_POUT  = 8'h18;
   localparam logic [7:0] IDX_CUR   = 8'h1A;
   localparam logic [7:0] IDX_MASK  = 8'h20;
   // ----------------------------------------
   // fault flag register fields
   // ----------------------------------------
   localparam int B_RSV     = 15;
   localparam int B_I2C     = 14;
   localparam int B_I2C_CLR = 13;
   localparam int B_BAD     = 12;
   localparam int B_BAD_CLR = 11;
   localparam int B_SUM     = 10;
   localparam int B_SUM_CLR = 9;
   localparam int B_GND     = 8;
   localparam int B_SHORT   = 7;
   localparam int B_OPEN    = 6;
   localparam int CHAN_MAX  = 6;
   localparam int STATE_W   = 5;
   localparam int CUR_W     = 12;
   localparam logic [15:0] REG_RST  = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   // ----------------------------------------
   // state machine view codes
   // ----------------------------------------
   localparam logic [4:0] ST_DISABLED = 5'h00;
   localparam logic [4:0] ST_REG_UP   = 5'h01;
   localparam logic [4:0] ST_MEM_RD   = 5'h02;
   localparam logic [4:0] ST_STANDBY  = 5'h03;
   localparam logic [4:0] ST_BOOST_LO = 5'h04;
   localparam logic [4:0] ST_BOOST_HI = 5'h0F;
   localparam logic [4:0] ST_NORMAL   = 5'h10;
   localparam logic [4:0] ST_SHUTDOWN = 5'h11;
   localparam logic [4:0] ST_RECOVERY = 5'h12;
   localparam logic [4:0] ST_ALL_FAIL = 5'h13;
   // ----------------------------------------
   // bus answers and types
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic       i2c_timeout_evt;
      logic       bad_string_evt;
      logic       open_det;
      logic       short_det;
      logic       gnd_det;
      logic [5:0] chan_fault;
   } bdsr_fault_t;
   typedef struct packed {
      logic [4:0]  state;
      logic [15:0] pwm_in;
      logic [15:0] pwm_out;
      logic [11:0] cur;
   } bdsr_view_t;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RESP = 2'b10
   } bdsr_bus_t;
endpackage

// ---- src/bdsr_regs.sv ----
// backlight diagnostic and fault status register bank
// assumes sync inputs on REF_CLK_I and an AXI4-Lite master
`timescale 1ns/1ps
module bdsr_regs #(
   parameter int CHAN_N = 6 // channels with fault bits
) (
   // clock and reset
   input  wire logic                         REF_CLK_I,
   input  wire logic                         ARST_N_I,
   // detector and view inputs
   input  wire bdsr_pkg::bdsr_fault_t        FAULT_I,
   input  wire bdsr_pkg::bdsr_view_t         VIEW_I,
   // write address channel
   input  wire logic [bdsr_pkg::ADDR_W-1:0]  S_AXI_AWADDR_I,
   input  wire logic                         S_AXI_AWVALID_I,
   output logic                              S_AXI_AWREADY_O,
   // write data channel
   input  wire logic [31:0]                  S_AXI_WDATA_I,
   input  wire logic [3:0]                   S_AXI_WSTRB_I,
   input  wire logic                         S_AXI_WVALID_I,
   output logic                              S_AXI_WREADY_O,
   // write response channel
   output logic [1:0]                        S_AXI_BRESP_O,
   output logic                              S_AXI_BVALID_O,
   input  wire logic                         S_AXI_BREADY_I,
   // read address channel
   input  wire logic [bdsr_pkg::ADDR_W-1:0]  S_AXI_ARADDR_I,
   input  wire logic                         S_AXI_ARVALID_I,
   output logic                              S_AXI_ARREADY_O,
   // read data channel
   output logic [31:0]                       S_AXI_RDATA_O,
   output logic [1:0]                        S_AXI_RRESP_O,
   output logic                              S_AXI_RVALID_O,
   input  wire logic                         S_AXI_RREADY_I,
   // interrupt
   output logic                              IRQ_O
);
   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (CHAN_N < 1 || CHAN_N > bdsr_pkg::CHAN_MAX)
   begin : g_bad_chan
      $error("CHAN_N must lie in 1..6");
   end

   // ----------------------------------------
   // decode helper
   // ----------------------------------------
   // true when byte address hits a register index
   function automatic logic hit(
      input logic [bdsr_pkg::ADDR_W-1:0] addr,
      input logic [7:0]                  idx
   );
      hit = (addr[bdsr_pkg::ADDR_W-1:2] == idx[5:0]);
   endfunction

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   bdsr_pkg::bdsr_bus_t              wr_st;      // write channel state
   bdsr_pkg::bdsr_bus_t              rd_st;      // read channel state
   logic                             aw_held;    // address captured
   logic                             w_held;     // data captured
   logic [bdsr_pkg::ADDR_W-1:0]      aw_addr;    // captured address
   logic [15:0]                      w_data;     // captured low data
   logic [1:0]                       w_strb;     // captured low lanes
   logic                             do_wr;      // write commits now
   logic                             wr_ok;      // address mapped
   logic [15:0]                      flags;      // fault flag register
   logic [15:0]                      irq_mask;   // interrupt mask
   logic [4:0]                       state_view; // state machine view
   logic [15:0]                      pin_view;   // input duty view
   logic [15:0]                      pout_view;  // output duty view
   logic [11:0]                      cur_view;   // current code view
   logic [5:0]                       chan_live;  // active channels
   logic                             flag_wr;    // flag register write commits
   logic                             clr_i2c;    // pair write hits
   logic                             clr_bad;
   logic                             clr_sum;
   logic                             sum_evt;    // open, short or ground fault
   logic [15:0]                      next_rdata; // read mux result
   logic                             next_rok;   // read mapped

   // ----------------------------------------
   // write channel
   // ----------------------------------------
   assign S_AXI_AWREADY_O = !aw_held && (wr_st == bdsr_pkg::BUS_IDLE);
   assign S_AXI_WREADY_O  = !w_held && (wr_st == bdsr_pkg::BUS_IDLE);
   assign do_wr = aw_held && w_held && (wr_st == bdsr_pkg::BUS_IDLE);
   assign wr_ok = hit(aw_addr, bdsr_pkg::IDX_FLAGS) || hit(aw_addr, bdsr_pkg::IDX_MASK);
   assign S_AXI_BVALID_O  = (wr_st == bdsr_pkg::BUS_RESP);

   // capture address and data in either order
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= bdsr_pkg::REG_RST;
         w_strb  <= 2'h0;
      end
      else if (do_wr)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
      end
      else
      begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
         begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
         end
         if (S_AXI_WVALID_I && S_AXI_WREADY_O)
         begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA_I[15:0];
            w_strb <= S_AXI_WSTRB_I[1:0];
         end
      end
   end

   // response state and code
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         wr_st         <= bdsr_pkg::BUS_IDLE;
         S_AXI_BRESP_O <= bdsr_pkg::RESP_OKAY;
      end
      else
      begin
         case (wr_st)
            bdsr_pkg::BUS_IDLE:
            begin
               if (do_wr)
               begin
                  wr_st         <= bdsr_pkg::BUS_RESP;
                  S_AXI_BRESP_O <= wr_ok ? bdsr_pkg::RESP_OKAY : bdsr_pkg::RESP_SLVERR;
               end
            end
            bdsr_pkg::BUS_RESP:
            begin
               if (S_AXI_BREADY_I)
                  wr_st <= bdsr_pkg::BUS_IDLE;
            end
            default:
               wr_st <= bdsr_pkg::BUS_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // clear decode and fault flags
   // ----------------------------------------
   // both status and clear bit in one write
   assign flag_wr = do_wr && hit(aw_addr, bdsr_pkg::IDX_FLAGS) && w_strb[1];
   assign clr_i2c = flag_wr && w_data[bdsr_pkg::B_I2C] && w_data[bdsr_pkg::B_I2C_CLR];
   assign clr_bad = flag_wr && w_data[bdsr_pkg::B_BAD] && w_data[bdsr_pkg::B_BAD_CLR];
   assign clr_sum = flag_wr && w_data[bdsr_pkg::B_SUM] && w_data[bdsr_pkg::B_SUM_CLR];
   // summary source: open, short or ground
   assign sum_evt = FAULT_I.open_det || FAULT_I.short_det || FAULT_I.gnd_det;

   // sticky flags, detection wins over clear
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         flags[15:6] <= bdsr_pkg::REG_RST[15:6];
      else
      begin
         flags[bdsr_pkg::B_RSV]     <= 1'b0;
         flags[bdsr_pkg::B_I2C_CLR] <= 1'b0;
         flags[bdsr_pkg::B_BAD_CLR] <= 1'b0;
         flags[bdsr_pkg::B_SUM_CLR] <= 1'b0;
         // host bus timeout
         if (FAULT_I.i2c_timeout_evt)
            flags[bdsr_pkg::B_I2C] <= 1'b1;
         else if (clr_i2c)
            flags[bdsr_pkg::B_I2C] <= 1'b0;
         // bad string config
         if (FAULT_I.bad_string_evt)
            flags[bdsr_pkg::B_BAD] <= 1'b1;
         else if (clr_bad)
            flags[bdsr_pkg::B_BAD] <= 1'b0;
         // summary flag
         if (sum_evt)
            flags[bdsr_pkg::B_SUM] <= 1'b1;
         else if (clr_sum)
            flags[bdsr_pkg::B_SUM] <= 1'b0;
         // ground indication
         if (FAULT_I.gnd_det)
            flags[bdsr_pkg::B_GND] <= 1'b1;
         else if (clr_sum)
            flags[bdsr_pkg::B_GND] <= 1'b0;
         // short and open follow the summary clear
         if (FAULT_I.short_det)
            flags[bdsr_pkg::B_SHORT] <= 1'b1;
         else if (clr_sum)
            flags[bdsr_pkg::B_SHORT] <= 1'b0;
         if (FAULT_I.open_det)
            flags[bdsr_pkg::B_OPEN] <= 1'b1;
         else if (clr_sum)
            flags[bdsr_pkg::B_OPEN] <= 1'b0;
      end
   end

   // per-channel live bits, bit n is channel n+1
   for (genvar g = 0; g < bdsr_pkg::CHAN_MAX; g++)
   begin : g_chan
      assign chan_live[g] = (g < CHAN_N) ? FAULT_I.chan_fault[g] : 1'b0;
      always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
      begin
         if (!ARST_N_I)
            flags[g] <= 1'b0;
         else
            flags[g] <= chan_live[g];
      end
   end

   // ----------------------------------------
   // mask register and interrupt
   // ----------------------------------------
   // mask shares the flag layout; only the timeout, string config and summary bits matter
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         irq_mask <= bdsr_pkg::MASK_RST;
      else if (do_wr && hit(aw_addr, bdsr_pkg::IDX_MASK))
      begin
         if (w_strb[0])
            irq_mask[7:0] <= w_data[7:0];
         if (w_strb[1])
            irq_mask[15:8] <= w_data[15:8];
      end
   end

   // level interrupt while an enabled flag stays set
   assign IRQ_O = (flags[bdsr_pkg::B_I2C] && irq_mask[bdsr_pkg::B_I2C])
               || (flags[bdsr_pkg::B_BAD] && irq_mask[bdsr_pkg::B_BAD])
               || (flags[bdsr_pkg::B_SUM] && irq_mask[bdsr_pkg::B_SUM]);

   // ----------------------------------------
   // diagnostic views
   // ----------------------------------------
   // live snapshots of the core, one cycle late
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         state_view <= bdsr_pkg::ST_DISABLED;
         pin_view   <= bdsr_pkg::REG_RST;
         pout_view  <= bdsr_pkg::REG_RST;
         cur_view   <= bdsr_pkg::REG_RST[11:0];
      end
      else
      begin
         state_view <= VIEW_I.state;   // codes as driven
         pin_view   <= VIEW_I.pwm_in;
         pout_view  <= VIEW_I.pwm_out;
         cur_view   <= VIEW_I.cur;
      end
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   assign S_AXI_ARREADY_O = (rd_st == bdsr_pkg::BUS_IDLE);
   assign S_AXI_RVALID_O  = (rd_st == bdsr_pkg::BUS_RESP);

   // read mux, unused upper bits read zero
   always_comb
   begin
      next_rdata = 16'h0000;
      next_rok   = 1'b1;
      if (hit(S_AXI_ARADDR_I, bdsr_pkg::IDX_FLAGS))
         next_rdata = flags;
      else if (hit(S_AXI_ARADDR_I, bdsr_pkg::IDX_FSM))
         next_rdata = {11'h000, state_view};
      else if (hit(S_AXI_ARADDR_I, bdsr_pkg::IDX_PIN))
         next_rdata = pin_view;
      else if (hit(S_AXI_ARADDR_I, bdsr_pkg::IDX_POUT))
         next_rdata = pout_view;
      else if (hit(S_AXI_ARADDR_I, bdsr_pkg::IDX_CUR))
         next_rdata = {4'h0, cur_view};
      else if (hit(S_AXI_ARADDR_I, bdsr_pkg::IDX_MASK))
         next_rdata = irq_mask;
      else
         next_rok = 1'b0;
   end

   // one read at a time, answer the cycle after the address
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         rd_st         <= bdsr_pkg::BUS_IDLE;
         S_AXI_RDATA_O <= 32'h0000_0000;
         S_AXI_RRESP_O <= bdsr_pkg::RESP_OKAY;
      end
      else
      begin
         case (rd_st)
            bdsr_pkg::BUS_IDLE:
            begin
               if (S_AXI_ARVALID_I)
               begin
                  rd_st         <= bdsr_pkg::BUS_RESP;
                  S_AXI_RDATA_O <= {16'h0000, next_rdata};
                  S_AXI_RRESP_O <= next_rok ? bdsr_pkg::RESP_OKAY : bdsr_pkg::RESP_SLVERR;
               end
            end
            bdsr_pkg::BUS_RESP:
            begin
               if (S_AXI_RREADY_I)
                  rd_st <= bdsr_pkg::BUS_IDLE;
            end
            default:
               rd_st <= bdsr_pkg::BUS_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   i2c_flag_set_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      FAULT_I.i2c_timeout_evt |=> flags[bdsr_pkg::B_I2C]) else $error("timeout flag not set");
   bad_flag_set_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      FAULT_I.bad_string_evt |=> flags[bdsr_pkg::B_BAD]) else $error("string config flag not set");
   sum_flag_set_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      sum_evt |=> flags[bdsr_pkg::B_SUM]) else $error("summary flag not set");
   pair_clear_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      $fell(flags[bdsr_pkg::B_SUM]) |-> $past(clr_sum)) else $error("summary cleared without pair write");
   open_with_sum_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (clr_sum && !sum_evt) |=> !flags[bdsr_pkg::B_OPEN] && !flags[bdsr_pkg::B_SHORT])
      else $error("open or short survived clear");
   chan_follow_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      ##1 flags[5:0] == $past(chan_live)) else $error("channel bits wrong");
   rsv_zero_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      !flags[bdsr_pkg::B_RSV]) else $error("reserved bit set");
   state_read_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (S_AXI_ARVALID_I && S_AXI_ARREADY_O && hit(S_AXI_ARADDR_I, bdsr_pkg::IDX_FSM))
      |=> S_AXI_RVALID_O && S_AXI_RDATA_O == {27'h0, $past(state_view)}) else $error("state read wrong");
   irq_level_a : assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
      (flags[bdsr_pkg::B_I2C] && irq_mask[bdsr_pkg::B_I2C]) |-> IRQ_O) else $error("interrupt low with flag set");
endmodule // bdsr_regs

// ---- test/tb_backlight_diag_status_regs.sv ----
// self-checking bench for the backlight diagnostic status register bank
// assumes bdsr_pkg compiled first; bench alone drives every port, no partner
`timescale 1ns/1ps
module tb_backlight_diag_status_regs;
   // ----------------------------------------
   // signals and bookkeeping
   // ----------------------------------------
   logic                  clk;          // 25 MHz reference clock
   logic                  arst_n;       // async reset, active low
   bdsr_pkg::bdsr_fault_t fault;        // detector inputs
   bdsr_pkg::bdsr_view_t  view;         // live view inputs
   logic [7:0]            awaddr;       // write address
   logic                  awvalid;      // write address valid
   logic                  awready;      // write address ready
   logic [31:0]           wdata;        // write data
   logic [3:0]            wstrb;        // write strobes
   logic                  wvalid;       // write data valid
   logic                  wready;       // write data ready
   logic [1:0]            bresp;        // write response
   logic                  bvalid;       // write response valid
   logic                  bready;       // write response ready
   logic [7:0]            araddr;       // read address
   logic                  arvalid;      // read address valid
   logic                  arready;      // read address ready
   logic [31:0]           rdata;        // read data
   logic [1:0]            rresp;        // read response
   logic                  rvalid;       // read data valid
   logic                  rready;       // read data ready
   logic                  irq;          // interrupt level
   logic [33:0]           note_q[$];    // expected {data, resp} per answer
   int                    fail_count;   // mismatches
   int                    tests_run;    // comparisons
   int                    seed;         // random seed
   logic [33:0]           note;         // oldest popped note
   // one comparison with counting and report
   `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
   // ----------------------------------------
   // design under test
   // ----------------------------------------
   bdsr_regs #(.CHAN_N(6)) i_bdsr_regs (
      .REF_CLK_I(clk), .ARST_N_I(arst_n), .FAULT_I(fault), .VIEW_I(view),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .IRQ_O(irq));
   // clock generator
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // byte address of a register index
   function automatic logic [7:0] ba(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction
   // verdict and end of run
   task automatic finish_test;
      if (fail_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one write; note the expected response first
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_hit, w_hit;
      note_q.push_back({32'h0000_0000, er});
      @(posedge clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'h3; wvalid <= 1'b1; bready <= 1'b1;
      aw_hit = 1'b0;
      w_hit  = 1'b0;
      // each channel released at its own handshake edge; only the watchdog ends a wait
      do
      begin
         @(negedge clk);
         aw_hit = aw_hit || (awready && awvalid);
         w_hit  = w_hit || (wready && wvalid);
         @(posedge clk);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit)  wvalid  <= 1'b0;
      end
      while (!(aw_hit && w_hit));
      // response: bready held until bvalid is sampled
      do
      begin
         @(negedge clk);
      end
      while (!bvalid);
      @(posedge clk);
      bready <= 1'b0;
   endtask
   // one read; note the expected data and response first
   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      note_q.push_back({ed, er});
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do
      begin
         @(negedge clk);
      end
      while (!arready);
      @(posedge clk);
      arvalid <= 1'b0;
      do
      begin
         @(negedge clk);
      end
      while (!rvalid);
      @(posedge clk);
      rready <= 1'b0;
   endtask
   // one-cycle detector pulse
   task automatic pulse(input bdsr_pkg::bdsr_fault_t f);
      @(posedge clk);
      fault <= f;
      @(posedge clk);
      fault <= '0;
   endtask
   // ----------------------------------------
   // answer monitor: oldest note against each handshake
   // ----------------------------------------
   always @(negedge clk)
   begin
      if ((rvalid && rready) || (bvalid && bready))
      begin
         if (note_q.size() == 0)
            note = 34'h3_FFFF_FFFF; // unexpected answer
         else
            note = note_q.pop_front();
         if (rvalid && rready)
            `CHK({rdata, rresp}, note)
         else
            `CHK({32'h0000_0000, bresp}, note)
      end
   end
   // watchdog well beyond the expected run
   initial
   begin
      #(40 * 20000);
      fail_count++;
      finish_test();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin : main
      logic [4:0]                codes[10];
      bdsr_pkg::bdsr_fault_t     evt[5];
      logic [15:0]               flg[5], part[5], full[5];
      logic [31:0]               r;
      codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13};
      evt = '{'{i2c_timeout_evt: 1'b1, default: '0}, '{bad_string_evt: 1'b1, default: '0},
              '{open_det: 1'b1, default: '0}, '{short_det: 1'b1, default: '0}, '{gnd_det: 1'b1, default: '0}};
      flg  = '{16'h4000, 16'h1000, 16'h0440, 16'h0480, 16'h0500};
      part = '{16'h2000, 16'h0800, 16'h0400, 16'h0200, 16'h0200};
      full = '{16'h6000, 16'h1800, 16'h0600, 16'h0600, 16'h0600};
      seed = 57;
      fail_count = 0; tests_run = 0;
      arst_n = 1'b0; fault = '0; view = '0;
      awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0; bready = 1'b0;
      araddr = '0; arvalid = 1'b0; rready = 1'b0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      // reset values of every register
      axi_read(ba(bdsr_pkg::IDX_FLAGS), 32'h0, bdsr_pkg::RESP_OKAY);
      axi_read(ba(bdsr_pkg::IDX_FSM), 32'h0, bdsr_pkg::RESP_OKAY);
      axi_read(ba(bdsr_pkg::IDX_PIN), 32'h0, bdsr_pkg::RESP_OKAY);
      axi_read(ba(bdsr_pkg::IDX_POUT), 32'h0, bdsr_pkg::RESP_OKAY);
      axi_read(ba(bdsr_pkg::IDX_CUR), 32'h0, bdsr_pkg::RESP_OKAY);
      axi_read(ba(bdsr_pkg::IDX_MASK), 32'h0, bdsr_pkg::RESP_OKAY);
      // every state code with random duty and current views
      foreach (codes[i])
      begin
         r = $random(seed);
         @(posedge clk);
         view <= '{state: codes[i], pwm_in: r[15:0], pwm_out: r[31:16], cur: r[27:16]};
         repeat (2) @(posedge clk);
         axi_read(ba(bdsr_pkg::IDX_FSM), {27'h0, codes[i]}, bdsr_pkg::RESP_OKAY);
         axi_read(ba(bdsr_pkg::IDX_PIN), {16'h0, r[15:0]}, bdsr_pkg::RESP_OKAY);
         axi_read(ba(bdsr_pkg::IDX_POUT), {16'h0, r[31:16]}, bdsr_pkg::RESP_OKAY);
         axi_read(ba(bdsr_pkg::IDX_CUR), {20'h0, r[27:16]}, bdsr_pkg::RESP_OKAY);
      end
      // writes to a view are refused and leave it alone; unmapped place refuses
      axi_write(ba(bdsr_pkg::IDX_FSM), 32'h0000_FFFF, bdsr_pkg::RESP_SLVERR);
      axi_read(ba(bdsr_pkg::IDX_FSM), 32'h0000_0013, bdsr_pkg::RESP_OKAY);
      axi_write(8'h04, 32'h0000_FFFF, bdsr_pkg::RESP_SLVERR);
      axi_read(8'h04, 32'h0, bdsr_pkg::RESP_SLVERR);
      // sticky flags: latch, mask, half clear refused, paired clear
      foreach (evt[i])
      begin
         axi_write(ba(bdsr_pkg::IDX_MASK), (i == 0) ? 32'h0 : 32'h0000_5400, bdsr_pkg::RESP_OKAY);
         axi_read(ba(bdsr_pkg::IDX_MASK), (i == 0) ? 32'h0 : 32'h0000_5400, bdsr_pkg::RESP_OKAY);
         pulse(evt[i]);
         repeat (3) @(posedge clk);
         axi_read(ba(bdsr_pkg::IDX_FLAGS), {16'h0, flg[i]}, bdsr_pkg::RESP_OKAY);
         @(negedge clk);
         `CHK(irq, (i != 0))
         axi_write(ba(bdsr_pkg::IDX_FLAGS), {16'h0, part[i]}, bdsr_pkg::RESP_OKAY);
         axi_read(ba(bdsr_pkg::IDX_FLAGS), {16'h0, flg[i]}, bdsr_pkg::RESP_OKAY);
         axi_write(ba(bdsr_pkg::IDX_FLAGS), {16'h0, full[i]}, bdsr_pkg::RESP_OKAY);
         axi_read(ba(bdsr_pkg::IDX_FLAGS), 32'h0, bdsr_pkg::RESP_OKAY);
         @(negedge clk);
         `CHK(irq, 1'b0)
      end
      // live channel faults, channel n+1 on bit n
      repeat (4)
      begin
         r = $random(seed);
         @(posedge clk);
         fault <= '{chan_fault: r[5:0], default: '0};
         repeat (2) @(posedge clk);
         axi_read(ba(bdsr_pkg::IDX_FLAGS), {26'h0, r[5:0]}, bdsr_pkg::RESP_OKAY);
      end
      @(posedge clk);
      fault <= '0;
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule // tb_backlight_diag_status_regs
